// ==== dv/sli_checker.sv ====
/* Port assertions for sli_top, bound to every instance.
   Assumes one pclk domain with presetn as its asynchronous reset. */
module sli_checker #(
    parameter int TICK_CYCLES = 10000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic robot_enabled,
    input wire logic can_ok,
    input wire logic boot_mode,
    input wire logic [15:0] vbat_mv,
    input wire logic log_start,
    input wire logic log_active,
    input wire logic log_abort,
    input wire logic vbat_fault,
    input wire logic stat_red,
    input wire logic stat_green,
    input wire logic comm_red,
    input wire logic comm_green
);
    int unsigned age;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 0;
        end else if (age < 600 * TICK_CYCLES) begin
            age <= age + 1;
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rise_in_log;
        log_active && $rose(robot_enabled);
    endsequence
    sequence abort_once;
        log_abort && !log_active ##1 !log_abort;
    endsequence
    blank_quiet_a: assert property (age < 499 * TICK_CYCLES |-> !vbat_fault)
        else $error("fault inside blanking");
    fault_level_a: assert property (age > 502 * TICK_CYCLES |->
        vbat_fault == ($past(vbat_mv) < sli_pkg::VBAT_MIN_MV)) else $error("bad fault level");
    abort_enable_a: assert property (rise_in_log |=> abort_once)
        else $error("no abort on enable");
    abort_cause_a: assert property (log_abort |-> $past(log_active) &&
        $past(robot_enabled) && !$past(robot_enabled, 2)) else $error("abort without cause");
    log_take_a: assert property (log_start && !log_active && !robot_enabled |=> log_active)
        else $error("log start not taken");
    leds_match_a: assert property (!boot_mode && !$past(boot_mode) && !$past(boot_mode, 2)
        |-> {stat_red, stat_green} == {comm_red, comm_green}) else $error("indicators differ");
    red_state_a: assert property (!$past(can_ok) && !$past(can_ok, 2) |-> !stat_green)
        else $error("green without link");
    green_fast_a: assert property ($past(can_ok) && $past(can_ok, 2) &&
        $past(robot_enabled) && $past(robot_enabled, 2) |-> !stat_red) else $error("red when on");
    boot_mix_a: assert property ($past(boot_mode) && $past(boot_mode, 2) && comm_red
        |-> comm_green) else $error("boot red alone");
endmodule

bind sli_top sli_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .robot_enabled(robot_enabled), .can_ok(can_ok), .boot_mode(boot_mode), .vbat_mv(vbat_mv),
    .log_start(log_start), .log_active(log_active), .log_abort(log_abort),
    .vbat_fault(vbat_fault), .stat_red(stat_red), .stat_green(stat_green),
    .comm_red(comm_red), .comm_green(comm_green));

// ==== dv/sli_host_model.sv ====
/* Host controller model: enable and link state, log extraction requests.
   Assumes the bench steers it through want_enabled and want_can. */
module sli_host_model #(
    parameter int LOG_LEN = 60
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_enabled,
    input wire logic want_can,
    input wire logic log_active,
    output logic robot_enabled,
    output logic can_ok,
    output logic log_start,
    output logic log_done
);
    int unsigned left;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            robot_enabled <= 1'h0;
            can_ok <= 1'h1;
            log_start <= 1'h0;
            log_done <= 1'h0;
            left <= 0;
        end else begin
            robot_enabled <= want_enabled;
            can_ok <= want_can;
            log_start <= robot_enabled && !want_enabled;
            log_done <= (left == 1) && log_active;
            left <= log_start ? LOG_LEN : (left != 0 ? left - 1 : 0);
        end
    end
endmodule

// ==== dv/sli_top_tb.sv ====
/* Self-checking bench for sli_top with the host model on the log link.
   Assumes shortened tick and blink parameters to keep the run brief. */
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module sli_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic en; logic can; logic [15:0] vb; logic [11:0] cur;
        logic [1:0] col; logic vf; logic [11:0] cout;} sli_row_t;
    localparam logic [11:0] CLR = sli_pkg::ADDR_CLEAR;
    localparam logic [11:0] IEN = sli_pkg::ADDR_IRQ_EN;
    localparam logic [11:0] STK = sli_pkg::ADDR_STICKY;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000, current_raw = 12'h000, current_out;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [15:0] vbat_mv = 16'h1388;
    logic want_en = 1'h0, want_can = 1'h1, boot_mode = 1'h0;
    logic pready, pslverr, robot_enabled, can_ok, log_start, log_done, log_active, log_abort;
    logic vbat_fault, stat_red, stat_green, comm_red, comm_green, irq, rerr;
    logic s_r, s_rng, c_r, diff, pg, fast_ok;
    int num_errors = 0, checks = 0, cyc = 0, aborts = 0, rises;
    // Colour code: 0 green only, 1 red only beside green (orange), 2 red alone.
    sli_row_t rows[7] = '{'{1'h1, 1'h1, 16'h2EE0, 12'h100, 2'h0, 1'h0, 12'h000},
        '{1'h0, 1'h1, 16'h2EE0, 12'h350, 2'h0, 1'h0, 12'h250},
        '{1'h0, 1'h1, 16'h1963, 12'h200, 2'h1, 1'h1, 12'h100},
        '{1'h0, 1'h1, 16'h1964, 12'h100, 2'h0, 1'h0, 12'h000},
        '{1'h0, 1'h0, 16'h2EE0, 12'h0FF, 2'h2, 1'h0, 12'h000},
        '{1'h1, 1'h1, 16'h1770, 12'h180, 2'h0, 1'h1, 12'h080},
        '{1'h1, 1'h0, 16'h2EE0, 12'hFFF, 2'h2, 1'h0, 12'hEFF}};
    sli_top #(.TICK_CYCLES(10), .FAST_HALF_MS(2), .SLOW_HALF_MS(4)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .robot_enabled(robot_enabled), .can_ok(can_ok), .boot_mode(boot_mode),
        .vbat_mv(vbat_mv), .current_raw(current_raw), .log_start(log_start),
        .log_done(log_done), .log_active(log_active), .log_abort(log_abort),
        .current_out(current_out), .vbat_fault(vbat_fault), .stat_red(stat_red),
        .stat_green(stat_green), .comm_red(comm_red), .comm_green(comm_green), .irq(irq));
    sli_host_model #(.LOG_LEN(60)) host (.pclk(pclk), .presetn(presetn),
        .want_enabled(want_en), .want_can(want_can), .log_active(log_active),
        .robot_enabled(robot_enabled), .can_ok(can_ok), .log_start(log_start),
        .log_done(log_done));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (log_abort === 1'h1) aborts++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // One idle cycle follows each transfer so no strobe is assigned twice in a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic watch(input int n);
        {s_r, s_rng, c_r, diff, pg} = 5'h00;
        rises = 0;
        repeat (n) begin
            @(posedge pclk);
            if (stat_red === 1'h1 && stat_green === 1'h0) s_rng = 1'h1;
            if (stat_red === 1'h1) s_r = 1'h1;
            if (comm_red === 1'h1) c_r = 1'h1;
            if ({stat_red, stat_green} !== {comm_red, comm_green}) diff = 1'h1;
            if (stat_green === 1'h1 && !pg) rises++;
            pg = stat_green;
        end
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, sli_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h00000002, rdata)
        apb(1'h0, 12'h020, 32'h0);
        `CHK("unmapped error", 1'h1, rerr)
        `CHK("unmapped data", 32'h0, rdata)
        repeat (4880) @(posedge pclk);
        `CHK("blanked fault", 1'h0, vbat_fault)
        repeat (150) @(posedge pclk);
        `CHK("late fault", 1'h1, vbat_fault)
        apb(1'h1, sli_pkg::ADDR_BIAS, 32'h100);
        foreach (rows[i]) begin
            want_en <= rows[i].en;
            want_can <= rows[i].can;
            vbat_mv <= rows[i].vb;
            current_raw <= rows[i].cur;
            repeat (3) @(posedge pclk);
            apb(1'h1, CLR, 32'h7);
            repeat (3) @(posedge pclk);
            watch(200);
            fast_ok = (rows[i].en && rows[i].can) ? (rises >= 4) : (rises <= 3);
            `CHK("colour", rows[i].col, {s_rng, s_r & !s_rng})
            `CHK("blink rate", 1'h1, fast_ok)
            `CHK("indicators", 1'h0, diff)
            `CHK("supply fault", rows[i].vf, vbat_fault)
            `CHK("current", rows[i].cout, current_out)
        end
        want_en <= 1'h0;
        want_can <= 1'h1;
        repeat (3) @(posedge pclk);
        apb(1'h1, CLR, 32'h7);
        vbat_mv <= 16'h1388;
        repeat (5) @(posedge pclk);
        vbat_mv <= 16'h2EE0;
        boot_mode <= 1'h1;
        watch(400);
        `CHK("boot orange", 1'h1, c_r)
        `CHK("boot differs", 1'h1, diff)
        boot_mode <= 1'h0;
        apb(1'h0, STK, 32'h0);
        `CHK("sticky kept", 32'h1, rdata)
        apb(1'h1, IEN, 32'h1);
        @(posedge pclk);
        `CHK("irq raised", 1'h1, irq)
        apb(1'h1, IEN, 32'h0);
        @(posedge pclk);
        `CHK("irq masked", 1'h0, irq)
        apb(1'h1, IEN, 32'h1);
        apb(1'h1, CLR, 32'h1);
        apb(1'h0, STK, 32'h0);
        `CHK("sticky cleared", 32'h0, rdata)
        `CHK("irq cleared", 1'h0, irq)
        want_en <= 1'h1;
        repeat (5) @(posedge pclk);
        aborts = 0;
        want_en <= 1'h0;
        repeat (10) @(posedge pclk);
        `CHK("log running", 1'h1, log_active)
        want_en <= 1'h1;
        repeat (5) @(posedge pclk);
        `CHK("abort pulses", 1, aborts)
        `CHK("log stopped", 1'h0, log_active)
        apb(1'h0, STK, 32'h0);
        `CHK("abort sticky", 32'h4, rdata)
        want_en <= 1'h0;
        repeat (100) @(posedge pclk);
        `CHK("log finished", 1'h0, log_active)
        `CHK("quiet finish", 1, aborts)
        // Capture takes the live reading as the new bias and keeps abort enabled.
        current_raw <= 12'h123;
        apb(1'h1, sli_pkg::ADDR_CTRL, 32'h3);
        apb(1'h0, sli_pkg::ADDR_BIAS, 32'h0);
        `CHK("captured bias", 32'h123, rdata)
        apb(1'h0, sli_pkg::ADDR_CURRENT, 32'h0);
        `CHK("zeroed current", 32'h0, rdata)
        apb(1'h0, sli_pkg::ADDR_CTRL, 32'h0);
        `CHK("capture self-clears", 32'h2, rdata)
        apb(1'h0, sli_pkg::ADDR_STATUS, 32'h0);
        `CHK("status", 32'h12, rdata)
        apb(1'h0, sli_pkg::ADDR_VBAT, 32'h0);
        `CHK("supply reading", 32'h2EE0, rdata)
        tally_and_finish();
    end
endmodule

// ==== inc/sli_pkg.sv ====
/*
 * Shared constants for the status and fault indicator block: register map,
 * field positions, reset values, thresholds and timing figures.
 * Assumes a single 10 MHz system clock and a 32-bit APB register bus.
 */
package sli_pkg;

    // Clock rate and the 1 ms time base derived from it.
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int TICK_TIME_MS = 1;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;

    // Supply measurement blanking after power-up, and the fault threshold.
    localparam int BLANK_TIME_MS = 500;
    localparam logic [9:0] BLANK_TICKS = 10'(BLANK_TIME_MS / TICK_TIME_MS);
    localparam logic [15:0] VBAT_MIN_MV = 16'h1964;

    // Register byte addresses.
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_STICKY = 12'h008;
    localparam logic [11:0] ADDR_CLEAR = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
    localparam logic [11:0] ADDR_BIAS = 12'h014;
    localparam logic [11:0] ADDR_CURRENT = 12'h018;
    localparam logic [11:0] ADDR_VBAT = 12'h01C;

    // Control register fields.
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam int CTRL_ABORT_EN_BIT = 1;
    localparam logic CTRL_ABORT_EN_RST = 1'b1;

    // Status register fields (live state).
    localparam int ST_ENABLED_BIT = 0;
    localparam int ST_CAN_OK_BIT = 1;
    localparam int ST_BOOT_BIT = 2;
    localparam int ST_VBAT_FAULT_BIT = 3;
    localparam int ST_BLANK_DONE_BIT = 4;
    localparam int ST_LOG_ACTIVE_BIT = 5;
    localparam int ST_WIDTH = 6;

    // Sticky event layout, shared by sticky, clear and enable registers.
    localparam int EV_UNDERVOLT_BIT = 0;
    localparam int EV_COMM_LOSS_BIT = 1;
    localparam int EV_LOG_ABORT_BIT = 2;
    localparam int EV_WIDTH = 3;
    localparam logic [EV_WIDTH-1:0] EV_FAULT_MASK = 3'h3;

    localparam int CUR_WIDTH = 12;
    localparam logic [CUR_WIDTH-1:0] BIAS_RST = 12'h000;
    localparam int PWM_WIDTH = 4;

    typedef enum logic [1:0] {
        SLI_OFF,
        SLI_GREEN,
        SLI_RED,
        SLI_ORANGE
    } sli_color_t;

    typedef enum logic {
        SLI_LOG_IDLE,
        SLI_LOG_XFER
    } sli_log_state_t;

endpackage

// ==== logic/sli_top.sv ====
/*
 * Status and fault indicator for a bus-attached power distribution unit: two indicators,
 * under-voltage fault with blanking, sticky faults, log abort, bias removal, APB registers.
 * Assumes robot, link, boot, log and measurement inputs come from logic on pclk, so they
 * are used without synchronisers.
 */
// Operation
// - Fast green enabled, slow green disabled, slow orange with fault, slow red without link.
// - Both indicators show the same colour and blink unless in boot-loader.
// - In boot-loader the communication indicator alone alternates green and orange.
// - Battery fault asserts whenever the supply reads below 6.5 V once the blanking time has ended.
// - Battery fault turns only the disabled indication orange; it also sets the sticky under-voltage event.
// - Supply readings are ignored for the first 500 ms after power-up.
// - Sticky faults survive field updates and clear only on explicit request.
// - When the host becomes enabled, any log extraction in progress is aborted.
// - Current-sense bias is subtracted so an unloaded channel reads 0 A.
module sli_top #(
    parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES,
    parameter int FAST_HALF_MS = 125,
    parameter int SLOW_HALF_MS = 500,
    parameter logic [3:0] ORANGE_RED_DUTY = 4'h8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic robot_enabled,
    input wire logic can_ok,
    input wire logic boot_mode,
    input wire logic [15:0] vbat_mv,
    input wire logic [11:0] current_raw,
    input wire logic log_start,
    input wire logic log_done,
    output logic log_active,
    output logic log_abort,
    output logic [11:0] current_out,
    output logic vbat_fault,
    output logic stat_red,
    output logic stat_green,
    output logic comm_red,
    output logic comm_green,
    output logic irq
);

    // Fast must stay shorter than slow; a bad override degrades to equal periods.
    localparam int FAST_MS = (FAST_HALF_MS < SLOW_HALF_MS) ? FAST_HALF_MS : SLOW_HALF_MS;

    // Maps a colour and blink phase onto the two dies of one indicator.
    function automatic logic [1:0] led_drive(input sli_pkg::sli_color_t color,
                                             input logic on,
                                             input logic red_slot);
        logic [1:0] rg;
        rg = 2'h0;
        if (on) begin
            case (color)
                sli_pkg::SLI_GREEN: rg = 2'h1;
                sli_pkg::SLI_RED: rg = 2'h2;
                sli_pkg::SLI_ORANGE: rg = {red_slot, 1'b1};
                default: rg = 2'h0;
            endcase
        end
        return rg;
    endfunction

    logic [13:0] tick_cnt;
    logic tick;
    logic [9:0] blank_cnt;
    logic blank_done;
    logic [9:0] fast_cnt, slow_cnt;
    logic fast_ph, slow_ph, boot_ph;
    logic [3:0] pwm_cnt;
    logic ctrl_abort_en;
    logic [sli_pkg::EV_WIDTH-1:0] sticky;
    logic [sli_pkg::EV_WIDTH-1:0] irq_en;
    logic [11:0] bias;
    logic enabled_d, can_ok_d;
    sli_pkg::sli_log_state_t log_state;
    logic [sli_pkg::EV_WIDTH-1:0] next_events;
    logic wr_en, setup, vbat_low, host_enable_edge;
    sli_pkg::sli_color_t main_color;
    logic main_on;
    logic [1:0] next_stat, next_comm;

    assign setup = psel && !penable && !pready;
    assign wr_en = psel && penable && pready && pwrite;
    assign vbat_low = blank_done && (vbat_mv < sli_pkg::VBAT_MIN_MV);
    assign host_enable_edge = robot_enabled && !enabled_d;

    // Millisecond time base shared by blanking and blink counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 14'h0000;
            tick <= 1'b0;
        end else if (tick_cnt == 14'(TICK_CYCLES - 1)) begin
            tick_cnt <= 14'h0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 14'h0001;
            tick <= 1'b0;
        end
    end

    // Connecting a battery or closing the main breaker bounces the supply.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_cnt <= 10'h000;
            blank_done <= 1'b0;
        end else if (tick && !blank_done) begin
            blank_cnt <= blank_cnt + 10'h001;
            blank_done <= (blank_cnt == sli_pkg::BLANK_TICKS - 10'h001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt <= 10'h000;
            fast_ph <= 1'b0;
        end else if (tick) begin
            if (fast_cnt == 10'(FAST_MS - 1)) begin
                fast_cnt <= 10'h000;
                fast_ph <= !fast_ph;
            end else begin
                fast_cnt <= fast_cnt + 10'h001;
            end
        end
    end

    // The boot pattern steps once per full slow period (every second half period): green, orange, green.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt <= 10'h000;
            slow_ph <= 1'b0;
            boot_ph <= 1'b0;
        end else if (tick) begin
            if (slow_cnt == 10'(SLOW_HALF_MS - 1)) begin
                slow_cnt <= 10'h000;
                slow_ph <= !slow_ph;
                boot_ph <= boot_ph ^ slow_ph;
            end else begin
                slow_cnt <= slow_cnt + 10'h001;
            end
        end
    end

    // Orange is red and green together, red gated to a share of 16 slots.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt <= 4'h0;
        end else begin
            pwm_cnt <= pwm_cnt + 4'h1;
        end
    end

    // Indication priority: no link, then enabled, then fault, then disabled.
    always_comb begin
        main_color = sli_pkg::SLI_GREEN;
        main_on = slow_ph;
        if (!can_ok) begin
            main_color = sli_pkg::SLI_RED;
        end else if (robot_enabled) begin
            main_on = fast_ph;
        end else if ((|(sticky & sli_pkg::EV_FAULT_MASK)) || vbat_low) begin
            main_color = sli_pkg::SLI_ORANGE;
        end
        next_stat = led_drive(main_color, main_on, pwm_cnt < ORANGE_RED_DUTY);
        next_comm = next_stat;
        if (boot_mode) begin
            next_comm = led_drive(boot_ph ? sli_pkg::SLI_ORANGE : sli_pkg::SLI_GREEN,
                                  slow_ph, pwm_cnt < ORANGE_RED_DUTY);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_red <= 1'b0;
            stat_green <= 1'b0;
            comm_red <= 1'b0;
            comm_green <= 1'b0;
        end else begin
            {stat_red, stat_green} <= next_stat;
            {comm_red, comm_green} <= next_comm;
        end
    end

    // Registered copy for this output and the status register; indicators, sticky and irq use vbat_low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbat_fault <= 1'b0;
        end else begin
            vbat_fault <= vbat_low;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled_d <= 1'b0;
            can_ok_d <= 1'b0;
        end else begin
            enabled_d <= robot_enabled;
            can_ok_d <= can_ok;
        end
    end

    // Extraction normally starts while disabled; finishing it after an enable
    // would hold the host disabled, so the enable edge cuts it short.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_state <= sli_pkg::SLI_LOG_IDLE;
            log_active <= 1'b0;
            log_abort <= 1'b0;
        end else begin
            log_abort <= 1'b0;
            case (log_state)
                sli_pkg::SLI_LOG_IDLE: begin
                    if (log_start && !robot_enabled) begin
                        log_state <= sli_pkg::SLI_LOG_XFER;
                        log_active <= 1'b1;
                    end
                end
                default: begin
                    if (host_enable_edge && ctrl_abort_en) begin
                        log_state <= sli_pkg::SLI_LOG_IDLE;
                        log_active <= 1'b0;
                        log_abort <= 1'b1;
                    end else if (log_done) begin
                        log_state <= sli_pkg::SLI_LOG_IDLE;
                        log_active <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_comb begin
        next_events = '0;
        next_events[sli_pkg::EV_UNDERVOLT_BIT] = vbat_low;
        next_events[sli_pkg::EV_COMM_LOSS_BIT] = can_ok_d && !can_ok;
        next_events[sli_pkg::EV_LOG_ABORT_BIT] = (log_state == sli_pkg::SLI_LOG_XFER)
            && host_enable_edge && ctrl_abort_en;
    end

    // Only reset and a clear write clear these; boot-loader entry does not.
    // A new event in the cycle of its clear survives.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky <= '0;
        end else begin
            if (wr_en && paddr == sli_pkg::ADDR_CLEAR) begin
                sticky <= (sticky & ~pwdata[sli_pkg::EV_WIDTH-1:0]) | next_events;
            end else begin
                sticky <= sticky | next_events;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sticky & irq_en);
        end
    end

    // Software registers; the capture bit is a command and never stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_abort_en <= sli_pkg::CTRL_ABORT_EN_RST;
            irq_en <= '0;
            bias <= sli_pkg::BIAS_RST;
        end else if (wr_en) begin
            if (paddr == sli_pkg::ADDR_CTRL) begin
                ctrl_abort_en <= pwdata[sli_pkg::CTRL_ABORT_EN_BIT];
                if (pwdata[sli_pkg::CTRL_CAPTURE_BIT]) begin
                    bias <= current_raw;
                end
            end else if (paddr == sli_pkg::ADDR_IRQ_EN) begin
                irq_en <= pwdata[sli_pkg::EV_WIDTH-1:0];
            end else if (paddr == sli_pkg::ADDR_BIAS) begin
                bias <= pwdata[sli_pkg::CUR_WIDTH-1:0];
            end
        end
    end

    // Readings under the bias floor to zero rather than wrapping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_out <= 12'h000;
        end else if (current_raw > bias) begin
            current_out <= current_raw - bias;
        end else begin
            current_out <= 12'h000;
        end
    end

    // No wait state: the answer is registered during the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == sli_pkg::ADDR_CTRL) begin
                prdata[sli_pkg::CTRL_ABORT_EN_BIT] <= ctrl_abort_en;
            end else if (paddr == sli_pkg::ADDR_STATUS) begin
                prdata[sli_pkg::ST_WIDTH-1:0] <= {log_active, blank_done, vbat_fault,
                                                  boot_mode, can_ok, robot_enabled};
            end else if (paddr == sli_pkg::ADDR_STICKY) begin
                prdata[sli_pkg::EV_WIDTH-1:0] <= sticky;
            end else if (paddr == sli_pkg::ADDR_CLEAR) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == sli_pkg::ADDR_IRQ_EN) begin
                prdata[sli_pkg::EV_WIDTH-1:0] <= irq_en;
            end else if (paddr == sli_pkg::ADDR_BIAS) begin
                prdata[sli_pkg::CUR_WIDTH-1:0] <= bias;
            end else if (paddr == sli_pkg::ADDR_CURRENT) begin
                prdata[sli_pkg::CUR_WIDTH-1:0] <= current_out;
            end else if (paddr == sli_pkg::ADDR_VBAT) begin
                prdata[15:0] <= vbat_mv;
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
